// file: hw/exec_ctrl_regs.svh
// register offsets, field positions, reset values and encodings for the execution control block
`ifndef EXEC_CTRL_REGS_SVH
`define EXEC_CTRL_REGS_SVH
`define WDOG_CTRL_OFF 12'h000
`define WDOG_THRESH_OFF 12'h004
`define WDOG_COUNT_OFF 12'h008
`define PRED_CTRL_OFF 12'h00c
`define PRED_SRC0_LO_OFF 12'h010
`define PRED_SRC0_HI_OFF 12'h014
`define PRED_SRC1_LO_OFF 12'h018
`define PRED_SRC1_HI_OFF 12'h01c
`define PRED_DATA_LO_OFF 12'h020
`define PRED_DATA_HI_OFF 12'h024
`define PRED_RESULT_OFF 12'h028
`define ALU_STATUS_OFF 12'h02c
`define GPR_BASE_OFF 12'h100
`define WDOG_MODE_BIT 31
`define WDOG_ENABLE_CODE 31'h00000000
`define WDOG_DISABLE_CODE 31'h00000001
`define WDOG_CTRL_RESET 32'h00000001
`define WDOG_THRESH_RESET 32'hffffffff
`define WDOG_IRQ_BIT 6
`define CMD_OPC_LSB 23
`define CMD_SET_PREDICATE 6'h01
`define CMD_PREDICATE 6'h0c
`define CMD_MATH 6'h1a
`define CMD_LRI 6'h22
`define CMD_SDI 6'h20
`define ALU_NOOP 12'h000
`define ALU_LOAD 12'h080
`define ALU_LOADINV 12'h480
`define ALU_LOAD0 12'h081
`define ALU_LOAD1 12'h481
`define ALU_ADD 12'h100
`define ALU_SUB 12'h101
`define ALU_AND 12'h102
`define ALU_OR 12'h103
`define ALU_XOR 12'h104
`define ALU_STORE 12'h180
`define ALU_STOREINV 12'h580
`define REG_ALU_OPERAND_A 10'h020
`define REG_ALU_OPERAND_B 10'h021
`define REG_ALU_RESULT_REGISTER 10'h031
`define REG_ZF 10'h032
`define REG_CF 10'h033
`endif

// file: hw/exec_ctrl_pkg.sv
// types shared by the execution control block
package exec_ctrl_pkg;
    // one command dword offered to the parser
    typedef struct packed {
        logic valid; // dword present
        logic first; // header dword of a command
        logic [31:0] data; // dword contents
    } cmd_word_t;
    // command parser state
    typedef enum logic [3:0] {
        ST_HDR = 4'b0001,
        ST_MATH = 4'b0010,
        ST_PASS = 4'b0100,
        ST_SKIP = 4'b1000
    } parse_state_t;
    // context state image of the watchdog
    typedef struct packed {
        logic [31:0] ctrl; // watchdog control
        logic [31:0] thresh; // watchdog threshold
    } wdog_ctx_t;
endpackage : exec_ctrl_pkg

// file: hw/cmd_stream_exec_control.sv
// watchdog, predicate state and math alu of a command streamer, apb register slave
`timescale 1ns/10ps
module cmd_stream_exec_control #(
    parameter int GPR_COUNT = 16, // general registers
    parameter logic [19:0] MMIO_BASE = 20'h00000 // this streamer's mmio window
) (
    input wire logic pclk, // engine clock, 125 mhz
    input wire logic presetn, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic [31:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire exec_ctrl_pkg::cmd_word_t cmd_in, // command dword stream
    output logic cmd_ready, // dword accepted
    output logic draw_issue, // draw command forwarded, one cycle
    output logic draw_skipped, // draw command dropped, one cycle
    input wire logic ts_toggle, // timestamp toggle pin
    input wire logic ctx_valid, // current context valid
    input wire logic execlist_en, // execution list enabled
    input wire logic ctx_restore, // load ctx_in into watchdog state
    input wire exec_ctrl_pkg::wdog_ctx_t ctx_in, // restored image
    output exec_ctrl_pkg::wdog_ctx_t ctx_out, // image to save
    output logic [31:0] iir_set // interrupt identity set pulses
);
`include "exec_ctrl_regs.svh"

    // apb decode
    logic acc; // access phase
    logic [11:0] off; // offset inside window
    logic in_win; // address in own window
    logic is_gpr; // gpr range hit
    logic [4:0] gpr_sel; // gpr dword index
    logic mapped; // decoded register
    logic wr; // write taken this edge
    assign acc = psel && penable;
    assign off = paddr[11:0];
    assign in_win = (paddr[31:12] == {12'h000, MMIO_BASE[7:0]});
    assign is_gpr = (off >= `GPR_BASE_OFF) && (off < `GPR_BASE_OFF + 12'(GPR_COUNT * 8));
    assign gpr_sel = 5'(off[7:2]);
    assign pready = 1'b1;
    assign wr = acc && pwrite && mapped && in_win && clk_en;

    // byte strobe merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                old[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return old;
    endfunction : merge

    // timestamp toggle synchroniser
    logic ts_s1_reg, ts_s2_reg, ts_s3_reg; // two sync stages and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ts_s1_reg <= 1'b0;
            ts_s2_reg <= 1'b0;
            ts_s3_reg <= 1'b0;
        end else if (clk_en) begin
            ts_s1_reg <= ts_toggle;
            ts_s2_reg <= ts_s1_reg;
            ts_s3_reg <= ts_s2_reg;
        end
    end

    // watchdog state
    logic [31:0] wctrl_reg, wctrl_next; // control
    logic [31:0] wthr_reg, wthr_next; // threshold
    logic [31:0] wcnt_reg, wcnt_next; // count
    logic wen_reg, wen_next; // effective enable
    logic wfire_reg, wfire_next; // threshold match pulse
    logic tick; // one count step

    // watchdog next state
    always_comb begin
        wctrl_next = wctrl_reg;
        wthr_next = wthr_reg;
        wcnt_next = wcnt_reg;
        wen_next = wen_reg;
        wfire_next = 1'b0;
        // context restore of ctrl and threshold
        if (ctx_restore) begin
            wctrl_next = ctx_in.ctrl;
            wthr_next = ctx_in.thresh;
        end
        if (wr && off == `WDOG_CTRL_OFF) begin
            wctrl_next = merge(wctrl_reg, pwdata, pstrb);
        end
        if (wr && off == `WDOG_THRESH_OFF) begin
            wthr_next = merge(wthr_reg, pwdata, pstrb);
        end
        if (wctrl_reg[30:0] == `WDOG_ENABLE_CODE) begin
            wen_next = 1'b1;
        end else if (wctrl_reg[30:0] == `WDOG_DISABLE_CODE) begin
            wen_next = 1'b0;
        end
        // other codes hold enable, count runs on while enabled
        if (wctrl_reg[30:0] == `WDOG_DISABLE_CODE) begin
            wcnt_next = 32'h0;
        end else if (wen_reg && wcnt_reg == wthr_reg) begin
            wcnt_next = 32'h0;
            wfire_next = 1'b1;
        // count gated by enable, context, execlist
        end else if (wen_reg && ctx_valid && execlist_en && tick) begin
            wcnt_next = wcnt_reg + 32'h1;
        end
    end
    // mode bit picks clock or toggle step
    assign tick = wctrl_reg[`WDOG_MODE_BIT] ? 1'b1 : (ts_s2_reg ^ ts_s3_reg);

    // watchdog registers, count is not restored from the image
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wctrl_reg <= `WDOG_CTRL_RESET;
            wthr_reg <= `WDOG_THRESH_RESET;
            wcnt_reg <= 32'h0;
            wen_reg <= 1'b0;
            wfire_reg <= 1'b0;
        end else if (clk_en) begin
            wctrl_reg <= wctrl_next;
            wthr_reg <= wthr_next;
            wcnt_reg <= wcnt_next;
            wen_reg <= wen_next;
            wfire_reg <= wfire_next;
        end
    end
    // image carries only ctrl and threshold
    assign ctx_out = '{ctrl: wctrl_reg, thresh: wthr_reg};
    assign iir_set = {25'h0, wfire_reg, 6'h0};

    // predicate and alu state
    logic [63:0] gpr_reg [GPR_COUNT]; // general registers
    logic [63:0] gpr_next [GPR_COUNT]; // next general registers
    logic [63:0] alu_operand_a_reg, alu_operand_a_next; // operand a
    logic [63:0] alu_operand_b_reg, alu_operand_b_next; // operand b
    logic [63:0] alu_result_register_reg, alu_result_register_next; // accumulator
    logic zf_reg, zf_next; // zero flag
    logic cf_reg, cf_next; // carry flag
    logic [63:0] psrc0_reg, psrc0_next; // predicate operand zero
    logic [63:0] psrc1_reg, psrc1_next; // predicate operand one
    logic [63:0] pdata_reg, pdata_next; // predicate data store
    logic [2:0] pres_reg, pres_next; // three predicate outcomes
    logic pen_reg, pen_next; // predicate enable bit, only read back over apb, the draw skip does not use it
    logic pstate_reg, pstate_next; // predicate state bit
    exec_ctrl_pkg::parse_state_t st_reg, st_next; // parser state
    logic [7:0] left_reg, left_next; // dwords left in command
    logic skip_reg, skip_next; // drop current body
    logic drw_reg, drw_next; // draw forwarded pulse
    logic dsk_reg, dsk_next; // draw dropped pulse
    logic [31:0] d; // current dword
    logic [5:0] opc; // mi opcode
    logic [64:0] sum; // adder with carry
    logic [63:0] src_val; // store source
    logic cmp; // predicate compare result
    assign d = cmd_in.data;
    assign opc = d[28:23];
    assign cmd_ready = 1'b1;

    // command parsing, alu and register writes
    always_comb begin
        gpr_next = gpr_reg;
        alu_operand_a_next = alu_operand_a_reg;
        alu_operand_b_next = alu_operand_b_reg;
        alu_result_register_next = alu_result_register_reg;
        zf_next = zf_reg;
        cf_next = cf_reg;
        psrc0_next = psrc0_reg;
        psrc1_next = psrc1_reg;
        pdata_next = pdata_reg;
        pres_next = pres_reg;
        pen_next = pen_reg;
        pstate_next = pstate_reg;
        st_next = st_reg;
        left_next = left_reg;
        skip_next = skip_reg;
        drw_next = 1'b0;
        dsk_next = 1'b0;
        sum = 65'h0;
        src_val = 64'h0;
        cmp = 1'b0;
        if (wr && is_gpr) begin
            if (gpr_sel[0]) begin
                gpr_next[gpr_sel[4:1]][63:32] = merge(gpr_reg[gpr_sel[4:1]][63:32], pwdata, pstrb);
            end else begin
                gpr_next[gpr_sel[4:1]][31:0] = merge(gpr_reg[gpr_sel[4:1]][31:0], pwdata, pstrb);
            end
        end
        if (wr) begin
            unique case (off)
                `PRED_SRC0_LO_OFF: psrc0_next[31:0] = pwdata;
                `PRED_SRC0_HI_OFF: psrc0_next[63:32] = pwdata;
                `PRED_SRC1_LO_OFF: psrc1_next[31:0] = pwdata;
                `PRED_SRC1_HI_OFF: psrc1_next[63:32] = pwdata;
                `PRED_DATA_LO_OFF: pdata_next[31:0] = pwdata;
                `PRED_DATA_HI_OFF: pdata_next[63:32] = pwdata;
                `PRED_CTRL_OFF: pstate_next = pwdata[0];
                default: ;
            endcase
        end
        if (cmd_in.valid) begin
            unique case (st_reg)
                exec_ctrl_pkg::ST_HDR: begin
                    if (opc == `CMD_SET_PREDICATE && d[31:29] == 3'b000) begin
                        pen_next = d[0];
                    end else if (opc == `CMD_PREDICATE && d[31:29] == 3'b000) begin
                        cmp = d[1] ? (psrc0_reg == psrc1_reg) : (pdata_reg != 64'h0);
                        unique case (d[4:3])
                            2'd0: pstate_next = cmp;
                            2'd1: pstate_next = pstate_reg & cmp;
                            2'd2: pstate_next = pstate_reg | cmp;
                            default: pstate_next = pstate_reg ^ cmp;
                        endcase
                        pstate_next = pstate_next ^ d[6];
                        pres_next = {pres_reg[1:0], pstate_next};
                    end else if (opc == `CMD_MATH && d[31:29] == 3'b000) begin
                        st_next = exec_ctrl_pkg::ST_MATH;
                        left_next = d[7:0] + 8'h1;
                    end else if (d[31:29] == 3'b011) begin
                        left_next = d[7:0] + 8'h1;
                        if (d[8] && pstate_reg) begin
                            st_next = exec_ctrl_pkg::ST_SKIP;
                            dsk_next = 1'b1;
                        end else begin
                            st_next = exec_ctrl_pkg::ST_PASS;
                            drw_next = 1'b1;
                        end
                    end
                end
                exec_ctrl_pkg::ST_MATH: begin
                    left_next = left_reg - 8'h1;
                    if (left_reg == 8'h1) begin
                        st_next = exec_ctrl_pkg::ST_HDR;
                    end
                    unique case (d[31:20])
                        `ALU_LOAD, `ALU_LOADINV, `ALU_LOAD0, `ALU_LOAD1: begin
                            src_val = (d[27:20] == 8'h81) ? {64{d[30]}} : (gpr_reg[d[3:0]] ^ {64{d[30]}});
                            if (d[19:10] == `REG_ALU_OPERAND_A) alu_operand_a_next = src_val;
                            else if (d[19:10] == `REG_ALU_OPERAND_B) alu_operand_b_next = src_val;
                        end
                        `ALU_ADD, `ALU_SUB, `ALU_AND, `ALU_OR, `ALU_XOR: begin
                            unique case (d[31:20])
                                `ALU_ADD: sum = {1'b0, alu_operand_a_reg} + {1'b0, alu_operand_b_reg};
                                `ALU_SUB: sum = {1'b0, alu_operand_a_reg} - {1'b0, alu_operand_b_reg};
                                `ALU_AND: sum = {1'b0, alu_operand_a_reg & alu_operand_b_reg};
                                `ALU_OR: sum = {1'b0, alu_operand_a_reg | alu_operand_b_reg};
                                default: sum = {1'b0, alu_operand_a_reg ^ alu_operand_b_reg};
                            endcase
                            alu_result_register_next = sum[63:0];
                            zf_next = (sum[63:0] == 64'h0);
                            cf_next = sum[64];
                        end
                        `ALU_STORE, `ALU_STOREINV: begin
                            unique case (d[9:0])
                                `REG_ZF: src_val = {64{zf_reg}};
                                `REG_CF: src_val = {64{cf_reg}};
                                default: src_val = alu_result_register_reg;
                            endcase
                            gpr_next[d[13:10]] = src_val ^ {64{d[30]}};
                        end
                        default: ;
                    endcase
                end
                exec_ctrl_pkg::ST_PASS, exec_ctrl_pkg::ST_SKIP: begin
                    left_next = left_reg - 8'h1;
                    if (left_reg == 8'h1) begin
                        st_next = exec_ctrl_pkg::ST_HDR;
                    end
                end
            endcase
        end
    end

    // predicate and alu registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < GPR_COUNT; i++) begin
                gpr_reg[i] <= 64'h0;
            end
            alu_operand_a_reg <= 64'h0;
            alu_operand_b_reg <= 64'h0;
            alu_result_register_reg <= 64'h0;
            zf_reg <= 1'b0;
            cf_reg <= 1'b0;
            psrc0_reg <= 64'h0;
            psrc1_reg <= 64'h0;
            pdata_reg <= 64'h0;
            pres_reg <= 3'h0;
            pen_reg <= 1'b0;
            pstate_reg <= 1'b0;
            st_reg <= exec_ctrl_pkg::ST_HDR;
            left_reg <= 8'h0;
            skip_reg <= 1'b0;
            drw_reg <= 1'b0;
            dsk_reg <= 1'b0;
        end else if (clk_en) begin
            gpr_reg <= gpr_next;
            alu_operand_a_reg <= alu_operand_a_next;
            alu_operand_b_reg <= alu_operand_b_next;
            alu_result_register_reg <= alu_result_register_next;
            zf_reg <= zf_next;
            cf_reg <= cf_next;
            psrc0_reg <= psrc0_next;
            psrc1_reg <= psrc1_next;
            pdata_reg <= pdata_next;
            pres_reg <= pres_next;
            pen_reg <= pen_next;
            pstate_reg <= pstate_next;
            st_reg <= st_next;
            left_reg <= left_next;
            skip_reg <= skip_next;
            drw_reg <= drw_next;
            dsk_reg <= dsk_next;
        end
    end
    assign draw_issue = drw_reg;
    assign draw_skipped = dsk_reg;

    // apb read mux and unmapped detection
    always_comb begin
        mapped = 1'b1;
        prdata = 32'h0;
        if (is_gpr) begin
            prdata = gpr_sel[0] ? gpr_reg[gpr_sel[4:1]][63:32] : gpr_reg[gpr_sel[4:1]][31:0];
        end else begin
            unique case (off)
                `WDOG_CTRL_OFF: prdata = wctrl_reg;
                `WDOG_THRESH_OFF: prdata = wthr_reg;
                `WDOG_COUNT_OFF: prdata = wcnt_reg;
                `PRED_CTRL_OFF: prdata = {30'h0, pen_reg, pstate_reg};
                `PRED_SRC0_LO_OFF: prdata = psrc0_reg[31:0];
                `PRED_SRC0_HI_OFF: prdata = psrc0_reg[63:32];
                `PRED_SRC1_LO_OFF: prdata = psrc1_reg[31:0];
                `PRED_SRC1_HI_OFF: prdata = psrc1_reg[63:32];
                `PRED_DATA_LO_OFF: prdata = pdata_reg[31:0];
                `PRED_DATA_HI_OFF: prdata = pdata_reg[63:32];
                `PRED_RESULT_OFF: prdata = {29'h0, pres_reg};
                `ALU_STATUS_OFF: prdata = {30'h0, cf_reg, zf_reg};
                default: mapped = 1'b0;
            endcase
        end
        if (!in_win) begin
            mapped = 1'b0;
            prdata = 32'h0;
        end
    end
    assign pslverr = acc && !mapped;

    wdog_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wctrl_reg[30:0] == `WDOG_DISABLE_CODE |=> wcnt_reg == 32'h0)
        else $error("watchdog count not cleared while disabled");
    // match pulses bit 6 and clears
    wdog_match_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wen_reg && wctrl_reg[30:0] != `WDOG_DISABLE_CODE && wcnt_reg == wthr_reg
        |=> iir_set[6] && wcnt_reg == 32'h0)
        else $error("threshold match missed");
    wdog_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !ctx_valid && wcnt_reg != wthr_reg |=> wcnt_reg <= $past(wcnt_reg))
        else $error("watchdog counted without valid context");
    wdog_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wctrl_reg[30:1] != 30'h0 |=> wen_reg == $past(wen_reg))
        else $error("enable changed on neutral control code");
    draw_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && cmd_in.valid && st_reg == exec_ctrl_pkg::ST_HDR && d[31:29] == 3'b011 && d[8] && pstate_reg
        |=> draw_skipped && !draw_issue)
        else $error("predicated draw not dropped");
    alu_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && st_reg == exec_ctrl_pkg::ST_MATH && cmd_in.valid && d[31:20] == `ALU_SUB && alu_operand_a_reg == alu_operand_b_reg
        |=> zf_reg && alu_result_register_reg == 64'h0 && !cf_reg)
        else $error("zero flag wrong after equal subtract");
    alu_add_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && st_reg == exec_ctrl_pkg::ST_MATH && cmd_in.valid && d[31:20] == `ALU_ADD
        |=> alu_result_register_reg == $past(alu_operand_a_reg) + $past(alu_operand_b_reg))
        else $error("accumulator not sum of operands");
    ctx_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && ctx_restore && !(acc && pwrite) |=> ctx_out == $past(ctx_in))
        else $error("context image not restored");
endmodule : cmd_stream_exec_control

// file: sim/cmd_stream_exec_control_test.sv
// self-checking bench for the execution control block
`timescale 1ns/10ps
`include "exec_ctrl_regs.svh"
module cmd_stream_exec_control_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0; // apb master side
    logic ts_toggle = 0, ctx_valid = 0, execlist_en = 0, ctx_restore = 0, clk_en = 1; // engine status
    logic [31:0] paddr = '0, pwdata = '0, prdata, iir_set; // buses
    logic pready, pslverr, draw_issue, draw_skipped; // observed
    exec_ctrl_pkg::cmd_word_t cmd_in = '0; // command stream
    exec_ctrl_pkg::wdog_ctx_t ctx_in = '0, ctx_out; // context image
    logic [32:0] rd_q[$]; // expected {pslverr, prdata}
    logic skip_q[$]; // expected draw drop flag
    int num_errors = 0, tests_run = 0, irq_cnt = 0;
    logic [63:0] a, b, r; // alu operands and result
    logic [11:0] ops[6] = '{`ALU_ADD, `ALU_SUB, `ALU_AND, `ALU_OR, `ALU_XOR, `ALU_SUB};
    always #4 pclk = ~pclk; // 125 mhz
    cmd_stream_exec_control dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_in(cmd_in), .cmd_ready(), .draw_issue(draw_issue), .draw_skipped(draw_skipped),
        .ts_toggle(ts_toggle), .ctx_valid(ctx_valid), .execlist_en(execlist_en), .ctx_restore(ctx_restore),
        .ctx_in(ctx_in), .ctx_out(ctx_out), .iir_set(iir_set));
    // compare seen against expected
    task automatic check(input logic [63:0] s, input logic [63:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    // monitor pops oldest note per result
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) check({pslverr, prdata}, rd_q.pop_front());
        if (draw_issue || draw_skipped) check(draw_skipped, skip_q.pop_front());
        if (iir_set[`WDOG_IRQ_BIT]) irq_cnt++;
    end
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rd(input logic [31:0] ad, input logic [32:0] e);
        rd_q.push_back(e);
        apb(0, ad, '0);
    endtask : rd
    task automatic gpr(input int n, input logic [63:0] v);
        apb(1, 32'h100 + 8 * n, v[31:0]);
        apb(1, 32'h104 + 8 * n, v[63:32]);
        rd(32'h100 + 8 * n, {1'b0, v[31:0]});
        rd(32'h104 + 8 * n, {1'b0, v[63:32]});
    endtask : gpr
    task automatic send(input logic f, input logic [31:0] d);
        @(posedge pclk);
        cmd_in <= {1'b1, f, d};
    endtask : send
    // toggle the timestamp pin n times, slowly
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge pclk) ts_toggle <= ~ts_toggle;
            repeat (4) @(posedge pclk);
        end
    endtask : tick
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(40));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rd(`WDOG_CTRL_OFF, {1'b0, `WDOG_CTRL_RESET});
        rd(`WDOG_THRESH_OFF, {1'b0, `WDOG_THRESH_RESET});
        rd(32'h800, {1'b1, 32'h0});
        // toggle mode counts pin edges only when context and list are live
        ctx_valid <= 1;
        execlist_en <= 1;
        apb(1, `WDOG_THRESH_OFF, 32'd1000);
        apb(1, `WDOG_CTRL_OFF, 32'h0);
        tick(3);
        rd(`WDOG_COUNT_OFF, {1'b0, 32'd3});
        apb(1, `WDOG_CTRL_OFF, 32'h5);
        tick(1);
        rd(`WDOG_COUNT_OFF, {1'b0, 32'd4});
        ctx_valid <= 0;
        tick(1);
        ctx_valid <= 1;
        execlist_en <= 0;
        tick(1);
        execlist_en <= 1;
        rd(`WDOG_COUNT_OFF, {1'b0, 32'd4});
        apb(1, `WDOG_CTRL_OFF, 32'h80000001);
        apb(1, `WDOG_CTRL_OFF, 32'h80000007);
        tick(2);
        rd(`WDOG_COUNT_OFF, {1'b0, 32'd0});
        // clock mode, threshold 5 wraps every few cycles
        apb(1, `WDOG_THRESH_OFF, 32'd5);
        apb(1, `WDOG_CTRL_OFF, 32'h80000000);
        repeat (40) @(posedge pclk);
        apb(1, `WDOG_CTRL_OFF, 32'h1);
        // let the last write settle before looking at the image
        @(posedge pclk);
        check(irq_cnt inside {[5:8]}, 1);
        check(ctx_out, {32'h1, 32'd5});
        // frozen block ignores a bus write
        clk_en <= 0;
        apb(1, `WDOG_THRESH_OFF, 32'd7);
        rd(`WDOG_THRESH_OFF, {1'b0, 32'd5});
        clk_en <= 1;
        ctx_in <= {32'h1, $urandom};
        ctx_restore <= 1;
        @(posedge pclk) ctx_restore <= 0;
        rd(`WDOG_THRESH_OFF, {1'b0, ctx_in.thresh});
        for (int n = 0; n < 16; n++) gpr(n, {$urandom, $urandom});
        // math command: load R0,R1, operate, store alu_result_register and zero flag
        for (int i = 0; i < 6; i++) begin
            a = {$urandom, $urandom};
            b = (i == 5) ? a : {$urandom, $urandom};
            r = ops[i] == `ALU_ADD ? a + b : ops[i] == `ALU_SUB ? a - b : ops[i] == `ALU_AND ? a & b :
                ops[i] == `ALU_OR ? a | b : a ^ b;
            gpr(0, a);
            gpr(1, b);
            send(1, {3'b000, `CMD_MATH, 15'h0, 8'h04});
            send(0, {`ALU_LOAD, `REG_ALU_OPERAND_A, 10'h000});
            send(0, {`ALU_LOAD, `REG_ALU_OPERAND_B, 10'h001});
            send(0, {ops[i], 20'h0});
            send(0, {`ALU_STORE, 10'h002, `REG_ALU_RESULT_REGISTER});
            send(0, {`ALU_STORE, 10'h003, `REG_ZF});
            @(posedge pclk) cmd_in.valid <= 0;
            rd(32'h110, {1'b0, r[31:0]});
            rd(32'h114, {1'b0, r[63:32]});
            rd(32'h118, {1'b0, {32{r == 0}}});
        end
        // draw dropped only with its enable bit and predicate state both set
        for (int i = 0; i < 4; i++) begin
            apb(1, `PRED_CTRL_OFF, {31'h0, i[0]});
            skip_q.push_back(i[0] & i[1]);
            send(1, {3'b011, 20'h0, i[1], 8'h00});
            send(0, $urandom);
            @(posedge pclk) cmd_in.valid <= 0;
            repeat (2) @(posedge pclk);
        end
        check(skip_q.size(), 0);
        // load equal operands first, then compare them into the predicate state
        a = {32'h0, $urandom};
        apb(1, `PRED_SRC0_LO_OFF, a[31:0]);
        apb(1, `PRED_SRC1_LO_OFF, a[31:0]);
        send(1, {3'b000, `CMD_PREDICATE, 23'h2});
        @(posedge pclk) cmd_in.valid <= 0;
        rd(`PRED_RESULT_OFF, {1'b0, 32'h1});
        // set the predicate enable bit, then read it back with the predicate state
        send(1, {3'b000, `CMD_SET_PREDICATE, 22'h0, 1'b1});
        @(posedge pclk) cmd_in.valid <= 0;
        rd(`PRED_CTRL_OFF, {1'b0, 32'h3});
        print_verdict();
    end
endmodule : cmd_stream_exec_control_test
